/* File: hw/gpio_event_unit.v */
`timescale 1ns/1ps
`include "gpio_pin_group_map.vh"

// ****************************************************************
// Event decode for one group: four inputs to set, clear, toggle masks
// ****************************************************************
module gpio_event_unit
(
    input wire [31:0] i_evctrl,
    input wire [3:0] i_event,
    output reg [31:0] o_set,
    output reg [31:0] o_clr,
    output reg [31:0] o_tgl
);

integer e;
reg [7:0] cfg;
reg [31:0] hit;

always @*
begin
    o_set = `GPIO_RST_WORD;
    o_clr = `GPIO_RST_WORD;
    o_tgl = `GPIO_RST_WORD;
    cfg = 8'h00;
    hit = `GPIO_RST_WORD;
    for (e = 0; e < `GPIO_EVENTS; e = e + 1)
    begin
        cfg = i_evctrl[e*`GPIO_EV_BYTE +: `GPIO_EV_BYTE];
        hit = `GPIO_RST_WORD;
        if (i_event[e] && cfg[`GPIO_EV_EN_BIT])
            hit[cfg[`GPIO_EV_PIN_LSB +: `GPIO_EV_PIN_W]] = 1'b1; // RL9
        case (cfg[`GPIO_EV_ACT_LSB +: `GPIO_EV_ACT_W])
            `GPIO_EV_ACT_SET: o_set = o_set | hit; // RL10
            `GPIO_EV_ACT_CLR: o_clr = o_clr | hit; // RL10
            `GPIO_EV_ACT_TGL: o_tgl = o_tgl ^ hit; // RL10
            default: o_set = o_set;
        endcase
    end
end

endmodule // gpio_event_unit

/* File: hw/gpio_pin_group_map.vh */
`ifndef GPIO_PIN_GROUP_MAP_VH
`define GPIO_PIN_GROUP_MAP_VH

// ****************************************************************
// Geometry
// ****************************************************************
`define GPIO_PINS 32
`define GPIO_GROUPS 2
`define GPIO_EVENTS 4
`define GPIO_ADDR_W 8
`define GPIO_GROUP_BIT 7

// ****************************************************************
// Register offsets inside one group, group stride 0x80
// ****************************************************************
`define GPIO_OFF_DIR 7'h00
`define GPIO_OFF_DIR_CLR 7'h04
`define GPIO_OFF_DIR_SET 7'h08
`define GPIO_OFF_DIR_TGL 7'h0C
`define GPIO_OFF_DRV_LEVEL 7'h10
`define GPIO_OFF_DRV_CLR 7'h14
`define GPIO_OFF_DRV_SET 7'h18
`define GPIO_OFF_DRV_TGL 7'h1C
`define GPIO_OFF_IN 7'h20
`define GPIO_OFF_EVCTRL 7'h2C
`define GPIO_OFF_PMUX_EN 7'h30
`define GPIO_OFF_PULL_EN 7'h34
`define GPIO_OFF_IN_EN 7'h38

// ****************************************************************
// Access kinds of a direction or drive register quartet
// ****************************************************************
`define GPIO_KIND_WRITE 2'h0
`define GPIO_KIND_CLR 2'h1
`define GPIO_KIND_SET 2'h2
`define GPIO_KIND_TGL 2'h3

// ****************************************************************
// Event control byte: pin [4:0], action [6:5], enable [7]
// ****************************************************************
`define GPIO_EV_BYTE 8
`define GPIO_EV_PIN_LSB 0
`define GPIO_EV_PIN_W 5
`define GPIO_EV_ACT_LSB 5
`define GPIO_EV_ACT_W 2
`define GPIO_EV_EN_BIT 7
`define GPIO_EV_ACT_SET 2'h0
`define GPIO_EV_ACT_CLR 2'h1
`define GPIO_EV_ACT_TGL 2'h2

// ****************************************************************
// Reset values
// ****************************************************************
`define GPIO_RST_WORD 32'h00000000
`define GPIO_RST_GROUP 64'h0000000000000000

`endif

/* File: hw/gpio_pin_group_output_control.v */
`timescale 1ns/1ps
`include "gpio_pin_group_map.vh"

// Contract
// RL1: Pins form groups of up to 32, controlled singly or together.
// RL2: One 8, 16 or 32 bit write changes selected pins only.
// RL3: Each pin is software GPIO or handed to a peripheral.
// RL4: Output pins drive low for level bit 0, high for 1.
// RL5: Pulled inputs: level bit 0 pulls down, 1 pulls up.
// RL6: Clear register at 0x14 forces written-one level bits low.
// RL7: Clear effects show at once in level, set and toggle reads.
// RL8: Each group has its own registers, 0x80 apart from 0x00.
// RL9: Four event inputs per group can act on a pin output.
// RL10: Each event selects set, clear or toggle of its pin.
// RL11: In standby configuration registers refuse access, data ones do not.
// RL12: Software can switch off an unused pin input buffer.
// RL13: Set and toggle registers act on ones, ignore zeros.

module gpio_pin_group_output_control
(
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire [3:0] i_pstrb,
    output reg [31:0] o_prdata,
    output wire o_pready,
    output wire o_pslverr,
    input wire i_standby,
    input wire [7:0] i_event,
    input wire [63:0] i_pin_in,
    output reg [63:0] o_pin_out,
    output reg [63:0] o_pin_oe,
    output reg [63:0] o_pull_en,
    output reg [63:0] o_pull_up,
    input wire [63:0] i_periph_out,
    input wire [63:0] i_periph_oe,
    output reg [63:0] o_periph_in
);

// ****************************************************************
// Helpers
// ****************************************************************
// Byte strobes to a 32 bit lane mask
function [31:0] byte_mask;
    input [3:0] strb;
    begin
        byte_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    end
endfunction

// A quartet is one stored word and its clear, set and toggle aliases
function in_quartet;
    input [6:0] off;
    input [6:0] base;
    begin
        in_quartet = (off[6:4] == base[6:4]) && (off[1:0] == 2'h0);
    end
endfunction

// Plain write keeps the lanes whose strobe is low
function [31:0] masked_write;
    input [31:0] cur;
    input [31:0] wd;
    input [31:0] m;
    begin
        masked_write = (cur & ~m) | (wd & m);
    end
endfunction

// Write, clear, set or toggle at a quartet starting at base
function [31:0] quartet_update;
    input [31:0] cur;
    input [31:0] wd;
    input [31:0] m;
    input [6:0] off;
    input [6:0] base;
    begin
        if (!in_quartet(off, base))
            quartet_update = cur;
        else
            case (off[3:2])
                `GPIO_KIND_WRITE: quartet_update = masked_write(cur, wd, m); // RL2
                `GPIO_KIND_CLR: quartet_update = cur & ~(wd & m); // RL6
                `GPIO_KIND_SET: quartet_update = cur | (wd & m); // RL13
                `GPIO_KIND_TGL: quartet_update = cur ^ (wd & m); // RL13
                default: quartet_update = cur;
            endcase
    end
endfunction

function is_cfg;
    input [6:0] off;
    begin
        is_cfg = (off == `GPIO_OFF_EVCTRL) || (off == `GPIO_OFF_PMUX_EN) ||
                 (off == `GPIO_OFF_PULL_EN) || (off == `GPIO_OFF_IN_EN);
    end
endfunction

function is_mapped;
    input [6:0] off;
    begin
        is_mapped = is_cfg(off) || (off == `GPIO_OFF_IN) ||
                    in_quartet(off, `GPIO_OFF_DIR) || in_quartet(off, `GPIO_OFF_DRV_LEVEL);
    end
endfunction

// Slice of a two group vector picked by the group bit
function [31:0] group_word;
    input [63:0] both;
    input sel;
    begin
        if (sel)
            group_word = both[63:32];
        else
            group_word = both[31:0];
    end
endfunction

// ****************************************************************
// Register storage, one 32 bit slice per group
// ****************************************************************
reg [63:0] dir;
reg [63:0] drive_level;
reg [63:0] pmux_en;
reg [63:0] pull_enable;
reg [63:0] in_en;
reg [63:0] evctrl;
wire [63:0] pin_sync;
wire [63:0] in_value;

// ****************************************************************
// Bus decode
// ****************************************************************
wire [6:0] off = i_paddr[6:0];
wire grp = i_paddr[`GPIO_GROUP_BIT]; // RL8
wire access = i_psel & i_penable;
// Configuration is fenced off in standby; data registers remain open
wire refused = ~is_mapped(off) | (is_cfg(off) & i_standby); // RL11
wire wr_ok = access & i_pwrite & ~refused;
wire [31:0] wmask = byte_mask(i_pstrb);

// ****************************************************************
// Bus answer, no wait states
// ****************************************************************
assign o_pready = 1'b1;
assign o_pslverr = access & refused;

// ****************************************************************
// Input path
// ****************************************************************
gpio_pin_sync u_pin_sync
(
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_async(i_pin_in),
    .o_sync(pin_sync)
);

// Disabled input buffers read as zero
assign in_value = pin_sync & in_en; // RL12

// ****************************************************************
// Per group update
// ****************************************************************
genvar g;
generate
    for (g = 0; g < `GPIO_GROUPS; g = g + 1)
    begin : grp_gen
        wire gsel = wr_ok & (grp == g);
        wire [31:0] ev_set;
        wire [31:0] ev_clr;
        wire [31:0] ev_tgl;
        wire [31:0] cur_level = drive_level[g*32 +: 32];
        wire [31:0] sw_level;
        wire [31:0] next_level;
        wire [31:0] next_dir;

        gpio_event_unit u_event
        (
            .i_evctrl(evctrl[g*32 +: 32]),
            .i_event(i_event[g*4 +: 4]),
            .o_set(ev_set),
            .o_clr(ev_clr),
            .o_tgl(ev_tgl)
        );

        assign sw_level = gsel ? quartet_update(cur_level, i_pwdata, wmask, off, `GPIO_OFF_DRV_LEVEL) : cur_level;
        // Software access lands first, a coincident event then acts on top
        assign next_level = ((sw_level & ~ev_clr) | ev_set) ^ ev_tgl; // RL10
        assign next_dir = gsel ? quartet_update(dir[g*32 +: 32], i_pwdata, wmask, off, `GPIO_OFF_DIR)
                               : dir[g*32 +: 32];

        always @(posedge i_clk_sys or negedge i_rst_n)
        begin
            if (!i_rst_n)
            begin
                dir[g*32 +: 32] <= `GPIO_RST_WORD;
                drive_level[g*32 +: 32] <= `GPIO_RST_WORD;
                pmux_en[g*32 +: 32] <= `GPIO_RST_WORD;
                pull_enable[g*32 +: 32] <= `GPIO_RST_WORD;
                in_en[g*32 +: 32] <= `GPIO_RST_WORD;
                evctrl[g*32 +: 32] <= `GPIO_RST_WORD;
            end
            else
            begin
                dir[g*32 +: 32] <= next_dir; // RL2
                drive_level[g*32 +: 32] <= next_level; // RL6
                if (gsel && off == `GPIO_OFF_PMUX_EN)
                    pmux_en[g*32 +: 32] <= masked_write(pmux_en[g*32 +: 32], i_pwdata, wmask); // RL3
                if (gsel && off == `GPIO_OFF_PULL_EN)
                    pull_enable[g*32 +: 32] <= masked_write(pull_enable[g*32 +: 32], i_pwdata, wmask); // RL5
                if (gsel && off == `GPIO_OFF_IN_EN)
                    in_en[g*32 +: 32] <= masked_write(in_en[g*32 +: 32], i_pwdata, wmask); // RL12
                if (gsel && off == `GPIO_OFF_EVCTRL)
                    evctrl[g*32 +: 32] <= masked_write(evctrl[g*32 +: 32], i_pwdata, wmask); // RL9
            end
        end
    end
endgenerate

// ****************************************************************
// Pin drive, registered so pads see no decode glitches
// ****************************************************************
// Handed-over pins follow the peripheral, all others the registers
wire [63:0] next_pin_out = (pmux_en & i_periph_out) | (~pmux_en & drive_level); // RL4
wire [63:0] next_pin_oe = (pmux_en & i_periph_oe) | (~pmux_en & dir); // RL3
// Pulls only on pins neither driven nor handed over
wire [63:0] next_pull_en = ~pmux_en & ~dir & pull_enable; // RL5
wire [63:0] next_periph_in = pin_sync & pmux_en; // RL3

always @(posedge i_clk_sys or negedge i_rst_n)
begin
    if (!i_rst_n)
    begin
        o_pin_out <= `GPIO_RST_GROUP;
        o_pin_oe <= `GPIO_RST_GROUP;
        o_pull_en <= `GPIO_RST_GROUP;
        o_pull_up <= `GPIO_RST_GROUP;
        o_periph_in <= `GPIO_RST_GROUP;
    end
    else
    begin
        o_pin_out <= next_pin_out; // RL4
        o_pin_oe <= next_pin_oe; // RL3
        o_pull_en <= next_pull_en; // RL5
        // Level doubles as pull direction; pads ignore it while driving
        o_pull_up <= drive_level; // RL5
        o_periph_in <= next_periph_in; // RL3
    end
end

// ****************************************************************
// Read path: sampled in setup phase so data stands in access phase
// ****************************************************************
reg [31:0] next_rdata;

always @*
begin
    next_rdata = `GPIO_RST_WORD;
    // Refused and unmapped reads return zero
    if (~refused)
    begin
        if (in_quartet(off, `GPIO_OFF_DIR))
            next_rdata = group_word(dir, grp);
        // All four aliases of the level register return the live value
        else if (in_quartet(off, `GPIO_OFF_DRV_LEVEL))
            next_rdata = group_word(drive_level, grp); // RL7
        else
        begin
            case (off)
                `GPIO_OFF_IN:
                    next_rdata = group_word(in_value, grp); // RL12
                `GPIO_OFF_EVCTRL:
                    next_rdata = group_word(evctrl, grp);
                `GPIO_OFF_PMUX_EN:
                    next_rdata = group_word(pmux_en, grp);
                `GPIO_OFF_PULL_EN:
                    next_rdata = group_word(pull_enable, grp);
                `GPIO_OFF_IN_EN:
                    next_rdata = group_word(in_en, grp);
                default:
                    next_rdata = `GPIO_RST_WORD;
            endcase
        end
    end
end

// ****************************************************************
// Read data register
// ****************************************************************

always @(posedge i_clk_sys or negedge i_rst_n)
begin
    if (!i_rst_n)
        o_prdata <= `GPIO_RST_WORD;
    else if (i_psel && !i_penable && !i_pwrite)
        o_prdata <= next_rdata; // RL1
end

endmodule // gpio_pin_group_output_control

/* File: hw/gpio_pin_sync.v */
`timescale 1ns/1ps
`include "gpio_pin_group_map.vh"

// ****************************************************************
// Two-stage synchroniser for pin levels
// ****************************************************************
module gpio_pin_sync
(
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire [63:0] i_async,
    output reg [63:0] o_sync
);

reg [63:0] meta;

always @(posedge i_clk_sys or negedge i_rst_n)
begin
    if (!i_rst_n)
    begin
        meta <= `GPIO_RST_GROUP;
        o_sync <= `GPIO_RST_GROUP;
    end
    else
    begin
        meta <= i_async;
        o_sync <= meta;
    end
end

endmodule // gpio_pin_sync

/* File: tb/gpio_pad_model.sv */
`timescale 1ns/1ps
// *****
// Pads and board wiring
// *****
module gpio_pad_model
(
    input wire i_clk_sys,
    input wire [63:0] i_pin_out,
    input wire [63:0] i_pin_oe,
    input wire [63:0] i_pull_en,
    input wire [63:0] i_pull_up,
    input wire [63:0] i_ext_val,
    input wire [63:0] i_ext_en,
    output logic [63:0] o_pad
);
    logic flip = 1'b0;
    always @(posedge i_clk_sys)
        flip <= ~flip;
    // A floating pad wanders every cycle, so no test can lean on a held level
    always_comb
        o_pad = (i_pin_oe & i_pin_out)
            | (~i_pin_oe & i_ext_en & i_ext_val)
            | (~i_pin_oe & ~i_ext_en & ((i_pull_en & i_pull_up) | (~i_pull_en & {64{flip}})));
endmodule // gpio_pad_model

/* File: tb/gpio_pin_group_output_control_assertions.sv */
`timescale 1ns/1ps
// *****
// Port checker
// *****
module gpio_pin_group_output_control_assertions
(
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire [3:0] i_pstrb,
    input wire o_pslverr,
    input wire i_standby,
    input wire [7:0] i_event,
    input wire [63:0] o_pin_oe,
    input wire [63:0] o_pin_out,
    input wire [63:0] o_pull_en,
    input wire [63:0] o_pull_up,
    input wire [63:0] i_periph_oe
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    wire acc = i_psel && i_penable;
    // Events in the write cycle would legally alter the result, so they are excluded
    wire wr = acc && i_pwrite && !(|i_event);
    wire cfg = i_paddr[6:0] inside {7'h2C, 7'h30, 7'h34, 7'h38};
    wire [31:0] m = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}}, {8{i_pstrb[1]}}, {8{i_pstrb[0]}}} & i_pwdata;
    wire [31:0] lv0 = o_pull_up[31:0];
    wire [31:0] lv1 = o_pull_up[63:32];
    // The pin copy of the level lags one cycle, so the pre-write value is seen one cycle before the result
    property clr_p;
        wr && i_paddr == 8'h14 |-> ##2 lv0 == ($past(lv0) & ~$past(m, 2));
    endproperty
    property set_p;
        wr && i_paddr == 8'h98 |-> ##2 lv1 == ($past(lv1) | $past(m, 2));
    endproperty
    property tgl_p;
        wr && i_paddr == 8'h1C |-> ##2 lv0 == ($past(lv0) ^ $past(m, 2));
    endproperty
    clear_group0_a: assert property (clr_p) else $error("clear write wrong");
    set_group1_a: assert property (set_p) else $error("group 1 set write wrong");
    toggle_group0_a: assert property (tgl_p) else $error("toggle write wrong");
    drive_level_a: assert property (((o_pin_out ^ o_pull_up) & o_pin_oe & ~$past(i_periph_oe)) == 64'h0)
        else $error("pin level differs from drive level");
    pull_exclusive_a: assert property ((o_pull_en & o_pin_oe) == 64'h0)
        else $error("pull on a driven pin");
    standby_refuse_a: assert property (acc && i_standby && cfg |-> o_pslverr) else $error("no refusal");
    data_open_a: assert property (acc && (!i_standby || !cfg) && i_paddr[6:0] <= 7'h20 && i_paddr[1:0] == 2'h0
        |-> !o_pslverr) else $error("data access refused");
    error_phase_a: assert property (o_pslverr |-> acc) else $error("error outside access");
    cover property (wr && i_paddr == 8'h14);
    cover property (acc && i_standby && cfg);
    cover property (|i_event);
endmodule // gpio_pin_group_output_control_assertions
bind gpio_pin_group_output_control gpio_pin_group_output_control_assertions chk
(
    .i_clk_sys, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_pslverr,
    .i_standby, .i_event, .o_pin_oe, .o_pin_out, .o_pull_en, .o_pull_up, .i_periph_oe
);

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
// *****
// Bench
// *****
module tb_top;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, standby, err;
    logic [7:0] paddr, ev;
    logic [3:0] pstrb;
    logic [31:0] pwdata, prdata, rd;
    logic [63:0] pad, pin_out, pin_oe, pull_en, pull_up, p_out, p_oe, p_in, ext_val, ext_en;
    int fail_count = 0;
    int n_checks = 0;
    gpio_pin_group_output_control dut
    (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_standby(standby), .i_event(ev), .i_pin_in(pad), .o_pin_out(pin_out),
        .o_pin_oe(pin_oe), .o_pull_en(pull_en), .o_pull_up(pull_up), .i_periph_out(p_out),
        .i_periph_oe(p_oe), .o_periph_in(p_in)
    );
    gpio_pad_model pads
    (
        .i_clk_sys(clk), .i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_pull_en(pull_en),
        .i_pull_up(pull_up), .i_ext_val(ext_val), .i_ext_en(ext_en), .o_pad(pad)
    );
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // No wait states, so the answer is taken at the edge that ends the access phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk({pready, err}, {1'b1, e});
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'h0, 1'b0);
        chk(rd, exp);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial
    begin
        #20000;
        fail_count++;
        tally_and_finish;
    end
    initial
    begin
        {rst_n, psel, penable, pwrite, standby} = 5'h0;
        {paddr, ev, pstrb, pwdata} = 52'h0;
        p_out = 64'h0000000100000000;
        p_oe = 64'h0000000100000000;
        ext_val = 64'h000000000000A500;
        ext_en = 64'h000000000000FF00;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(8'h10, 32'h0);
        rdchk(8'h14, 32'h0);
        bus(1'b1, 8'h18, 32'hF0F000FF, 4'hF, 1'b0);
        rdchk(8'h10, 32'hF0F000FF);
        bus(1'b1, 8'h14, 32'h0000000F, 4'h1, 1'b0);
        rdchk(8'h18, 32'hF0F000F0);
        rdchk(8'h1C, 32'hF0F000F0);
        bus(1'b1, 8'h1C, 32'hFFFFFFFF, 4'h3, 1'b0);
        rdchk(8'h14, 32'hF0F0FF0F);
        bus(1'b1, 8'h98, 32'h00000001, 4'hF, 1'b0);
        rdchk(8'h90, 32'h00000001);
        rdchk(8'h10, 32'hF0F0FF0F);
        bus(1'b1, 8'h08, 32'hFFFFFFFF, 4'hC, 1'b0);
        rdchk(8'h00, 32'hFFFF0000);
        bus(1'b1, 8'h34, 32'h000000FF, 4'hF, 1'b0);
        bus(1'b1, 8'h38, 32'hFFFFFFFF, 4'hF, 1'b0);
        repeat (4) @(posedge clk);
        chk({pin_oe[31:16], pin_out[31:16]}, {16'hFFFF, 16'hF0F0});
        chk({pull_en[31:0], pull_up[31:0]}, {32'h000000FF, 32'hF0F0FF0F});
        rdchk(8'h20, 32'hF0F0A50F);
        bus(1'b1, 8'h38, 32'h0, 4'hF, 1'b0);
        rdchk(8'h20, 32'h0);
        bus(1'b1, 8'hB0, 32'h00000001, 4'hF, 1'b0);
        repeat (6) @(posedge clk);
        chk({pin_oe[32], pin_out[32], p_in[32]}, 3'h7);
        bus(1'b1, 8'h2C, 32'hE59BA0C3, 4'hF, 1'b0);
        @(posedge clk);
        ev <= 8'h0F;
        @(posedge clk);
        ev <= 8'h00;
        rdchk(8'h10, 32'hF8F0FF06);
        standby <= 1'b1;
        bus(1'b1, 8'h34, 32'h0, 4'hF, 1'b1);
        bus(1'b0, 8'h34, 32'h0, 4'h0, 1'b1);
        chk({rd, pull_en[31:0]}, {32'h0, 32'h000000FF});
        bus(1'b1, 8'h18, 32'h00000010, 4'hF, 1'b0);
        rdchk(8'h10, 32'hF8F0FF16);
        standby <= 1'b0;
        bus(1'b1, 8'h34, 32'h0000000F, 4'hF, 1'b0);
        rdchk(8'h34, 32'h0000000F);
        bus(1'b1, 8'h24, 32'h0, 4'hF, 1'b1);
        bus(1'b1, 8'hAC, 32'h9F0000C0, 4'hF, 1'b0);
        @(posedge clk);
        ev <= 8'h90;
        @(posedge clk);
        ev <= 8'h00;
        rdchk(8'h90, 32'h80000000);
        bus(1'b1, 8'h10, 32'h12345678, 4'h2, 1'b0);
        rdchk(8'h10, 32'hF8F05616);
        bus(1'b1, 8'h04, 32'hFFFFFFFF, 4'h8, 1'b0);
        bus(1'b1, 8'h0C, 32'h0000FFFF, 4'hF, 1'b0);
        rdchk(8'h0C, 32'h00FFFFFF);
        tally_and_finish;
    end
endmodule // tb_top
